// *** pct_regs.svh ***
// Register map, field values and reset values of the pwm channel counter
// Behaviour
// - Eight-bit up counter used only for PWM
// - Overflow reloads count from reload register
// - Waveform keeps running in green mode
// - Mode bit 0 hands pin to waveform
// - Mode bits 2:1 pick period 256/64/32/16
// - Mode bit 3 picks instruction or oscillator
// - Instruction clock divides 256 down to 2
// - Oscillator clock divides 128 down to 1
// - Mode bit 7 starts and stops counter
// - Waveform on pin only with both enables
// - Each period starts high, ends low only if count steps onto reload
// - Output falls when count steps onto reload value
// - Overflow ends period, output rises again
// - Period changes apply from next reload
// - Clearing pin enable restores port control
// - All registers reset zero; reload write-only
`ifndef PCT_REGS_SVH
`define PCT_REGS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define PCT_IDX_MODE 8'hA0
`define PCT_IDX_COUNT 8'hA1
`define PCT_IDX_RELOAD 8'hA2
`define PCT_ADDR_MODE ({2'h0, `PCT_IDX_MODE, 2'h0})
`define PCT_ADDR_COUNT ({2'h0, `PCT_IDX_COUNT, 2'h0})
`define PCT_ADDR_RELOAD ({2'h0, `PCT_IDX_RELOAD, 2'h0})

// ----------------------------------------------------------------
// Reset values, ranges and bus answers
// ----------------------------------------------------------------
`define PCT_RST_BYTE 8'h00
`define PCT_RES_256 2'h0
`define PCT_RES_64 2'h1
`define PCT_RES_32 2'h2
`define PCT_TOP_256 8'hFF
`define PCT_TOP_64 8'h3F
`define PCT_TOP_32 8'h1F
`define PCT_TOP_16 8'h0F
`define PCT_EXP_CPU 4'h8
`define PCT_EXP_HOSC 4'h7
`define PCT_RESP_OKAY 2'h0
`define PCT_RESP_SLVERR 2'h2
`define PCT_RDATA_ZERO 32'h00000000

`endif

// *** pct_pkg.sv ***
// Types and shared functions of the pwm channel counter
`default_nettype none
`include "pct_regs.svh"
package pct_pkg;
    typedef struct packed {
        logic run_en;
        logic [2:0] rate;
        logic src_hosc;
        logic [1:0] res;
        logic pin_en;
    } pct_mode_s;

    typedef enum logic {
        PCT_BUS_IDLE = 1'b0,
        PCT_BUS_RESP = 1'b1
    } pct_bus_e;

    // Highest count of the selected resolution
    function automatic logic [7:0] pct_top(input logic [1:0] res);
        logic [7:0] top;
        top = `PCT_TOP_16;
        unique case (res)
            `PCT_RES_256: top = `PCT_TOP_256;
            `PCT_RES_64: top = `PCT_TOP_64;
            `PCT_RES_32: top = `PCT_TOP_32;
            default: top = `PCT_TOP_16;
        endcase
        return top;
    endfunction
endpackage
`default_nettype wire

// *** pct_prescaler.sv ***
// Prescaler of the pwm channel counter: source select and power-of-two divider
`default_nettype none
`include "pct_regs.svh"
module pct_prescaler
    import pct_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // Settings
    input wire logic i_run,
    input wire logic i_src_hosc,
    input wire logic [2:0] i_rate,
    // Source ticks
    input wire logic i_cpu_tick,
    input wire logic i_hosc_tick,
    // Divided tick
    output logic o_tick
);
    logic [7:0] div_ff;
    logic tick_ff;
    wire logic src_tick;
    wire logic [3:0] div_exp;
    wire logic [7:0] div_mask;
    wire logic div_done;

    assign src_tick = i_src_hosc ? i_hosc_tick : i_cpu_tick;
    assign div_exp = i_src_hosc ? (`PCT_EXP_HOSC - {1'b0, i_rate}) : (`PCT_EXP_CPU - {1'b0, i_rate});
    assign div_mask = 8'((9'h001 << div_exp) - 9'h001);
    assign div_done = src_tick && ((div_ff & div_mask) == div_mask);

    // Divider restarts while stopped so every run begins on a full prescale period
    always_ff @(posedge i_clock) begin
        if (i_srst || !i_run) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else begin
            div_ff <= src_tick ? 8'(div_ff + 8'h01) : div_ff;
            tick_ff <= div_done;
        end
    end

    assign o_tick = tick_ff;
endmodule
`default_nettype wire

// *** pct_pin_mux.sv ***
// Shared port pin hand-over between port logic and the pwm waveform
`default_nettype none
module pct_pin_mux (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // Control
    input wire logic i_pin_en,
    input wire logic i_run,
    input wire logic i_wave,
    // Port logic drive
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe,
    // Pin drive
    output logic o_pin_out,
    output logic o_pin_oe
);
    logic pin_out_ff;
    logic pin_oe_ff;
    wire logic nxt_pin_out;
    wire logic nxt_pin_oe;

    // Owned pin idles low while the counter is stopped
    assign nxt_pin_out = i_pin_en ? (i_run & i_wave) : i_gpio_out;
    assign nxt_pin_oe = i_pin_en ? 1'b1 : i_gpio_oe;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    assign o_pin_out = pin_out_ff;
    assign o_pin_oe = pin_oe_ff;
endmodule
`default_nettype wire

// *** pct_top.sv ***
// PWM channel counter with its AXI4-Lite register slave
`default_nettype none
`include "pct_regs.svh"
module pct_top
    import pct_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // AXI4-Lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [11:0] i_awaddr,
    // AXI4-Lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [11:0] i_araddr,
    // AXI4-Lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Prescaler sources from clock generation
    input wire logic i_cpu_tick,
    input wire logic i_hosc_tick,
    // Port logic drive of the shared pin
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe,
    // Shared pin drive
    output logic o_pin_out,
    output logic o_pin_oe
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    pct_mode_s mode_ff;
    logic [7:0] count_ff;
    logic [7:0] reload_ff;
    logic pwm_ff;
    logic [1:0] act_res_ff;
    logic [2:0] act_rate_ff;
    logic act_src_ff;

    pct_bus_e wr_state_ff;
    pct_bus_e rd_state_ff;
    logic awready_ff;
    logic wready_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [11:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    wire logic pre_tick;

    // ----------------------------------------------------------------
    // Write channel decode
    // ----------------------------------------------------------------
    wire logic aw_take;
    wire logic w_take;
    wire logic aw_have;
    wire logic w_have;
    wire logic do_write;
    wire logic [11:0] wr_addr;
    wire logic [7:0] wr_byte;
    wire logic wr_lane0;
    wire logic wr_hit_mode;
    wire logic wr_hit_count;
    wire logic wr_hit_reload;
    wire logic wr_mapped;
    wire logic b_done;
    wire pct_bus_e nxt_wr_state;
    wire logic nxt_aw_got;
    wire logic nxt_w_got;

    assign aw_take = i_awvalid & awready_ff;
    assign w_take = i_wvalid & wready_ff;
    assign aw_have = aw_got_ff | aw_take;
    assign w_have = w_got_ff | w_take;
    assign do_write = aw_have & w_have & (wr_state_ff == PCT_BUS_IDLE);
    assign wr_addr = aw_got_ff ? aw_addr_ff : i_awaddr;
    assign wr_byte = w_got_ff ? w_data_ff[7:0] : i_wdata[7:0];
    assign wr_lane0 = w_got_ff ? w_strb_ff[0] : i_wstrb[0];
    assign wr_hit_mode = do_write & (wr_addr == `PCT_ADDR_MODE);
    assign wr_hit_count = do_write & (wr_addr == `PCT_ADDR_COUNT);
    assign wr_hit_reload = do_write & (wr_addr == `PCT_ADDR_RELOAD);
    assign wr_mapped = wr_hit_mode | wr_hit_count | wr_hit_reload;
    assign b_done = bvalid_ff & i_bready;
    assign nxt_wr_state = do_write ? PCT_BUS_RESP : (b_done ? PCT_BUS_IDLE : wr_state_ff);
    assign nxt_aw_got = aw_have & ~do_write;
    assign nxt_w_got = w_have & ~do_write;

    // ----------------------------------------------------------------
    // Write channel registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            wr_state_ff <= PCT_BUS_IDLE;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PCT_RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            awready_ff <= (nxt_wr_state == PCT_BUS_IDLE) & ~nxt_aw_got;
            wready_ff <= (nxt_wr_state == PCT_BUS_IDLE) & ~nxt_w_got;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            bvalid_ff <= do_write | (bvalid_ff & ~i_bready);
            bresp_ff <= do_write ? (wr_mapped ? `PCT_RESP_OKAY : `PCT_RESP_SLVERR) : bresp_ff;
        end
    end

    // Payload holders need no reset: they are read only behind the got flags
    always_ff @(posedge i_clock) begin
        aw_addr_ff <= aw_take ? i_awaddr : aw_addr_ff;
        w_data_ff <= w_take ? i_wdata : w_data_ff;
        w_strb_ff <= w_take ? i_wstrb : w_strb_ff;
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    wire logic ar_take;
    wire logic r_done;
    wire pct_bus_e nxt_rd_state;
    wire logic rd_hit_mode;
    wire logic rd_hit_count;
    wire logic rd_hit_reload;
    wire logic [31:0] rd_word;

    assign ar_take = i_arvalid & arready_ff;
    assign r_done = rvalid_ff & i_rready;
    assign nxt_rd_state = ar_take ? PCT_BUS_RESP : (r_done ? PCT_BUS_IDLE : rd_state_ff);
    assign rd_hit_mode = (i_araddr == `PCT_ADDR_MODE);
    assign rd_hit_count = (i_araddr == `PCT_ADDR_COUNT);
    assign rd_hit_reload = (i_araddr == `PCT_ADDR_RELOAD);
    // Reload register is write-only and reads back as zero
    assign rd_word = rd_hit_mode ? {24'h000000, mode_ff} :
                     rd_hit_count ? {24'h000000, count_ff} : `PCT_RDATA_ZERO;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rd_state_ff <= PCT_BUS_IDLE;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= `PCT_RDATA_ZERO;
            rresp_ff <= `PCT_RESP_OKAY;
        end else begin
            rd_state_ff <= nxt_rd_state;
            arready_ff <= (nxt_rd_state == PCT_BUS_IDLE);
            rvalid_ff <= ar_take | (rvalid_ff & ~i_rready);
            rdata_ff <= ar_take ? rd_word : rdata_ff;
            if (ar_take) begin
                rresp_ff <= (rd_hit_mode | rd_hit_count | rd_hit_reload) ? `PCT_RESP_OKAY : `PCT_RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Counter and waveform
    // ----------------------------------------------------------------
    wire logic sw_count_wr;
    wire logic run;
    wire logic [7:0] top;
    wire logic [7:0] count_inc;
    wire logic step;
    wire logic ovf;
    wire logic duty_hit;
    wire logic take_settings;
    wire logic [7:0] nxt_count;
    wire logic nxt_pwm;

    assign sw_count_wr = wr_hit_count & wr_lane0;
    assign run = mode_ff.run_en;
    assign top = pct_top(act_res_ff);
    assign count_inc = 8'(count_ff + 8'h01);
    // No sleep gating: the counter keeps stepping while the core idles in green mode
    assign step = run & pre_tick;
    assign ovf = step & ((count_ff & top) == top);
    assign duty_hit = step & ~ovf & ((count_inc & top) == (reload_ff & top));
    assign take_settings = ~run | ovf;
    // A software write to the count wins over the counter's own update
    assign nxt_count = sw_count_wr ? wr_byte : ovf ? reload_ff : step ? count_inc : count_ff;
    assign nxt_pwm = (~run | ovf) ? 1'b1 : duty_hit ? 1'b0 : pwm_ff;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            mode_ff <= pct_mode_s'(`PCT_RST_BYTE);
            count_ff <= `PCT_RST_BYTE;
            reload_ff <= `PCT_RST_BYTE;
            pwm_ff <= 1'b1;
            act_res_ff <= `PCT_RES_256;
            act_rate_ff <= 3'h0;
            act_src_ff <= 1'b0;
        end else begin
            mode_ff <= (wr_hit_mode & wr_lane0) ? pct_mode_s'(wr_byte) : mode_ff;
            count_ff <= nxt_count;
            reload_ff <= (wr_hit_reload & wr_lane0) ? wr_byte : reload_ff;
            pwm_ff <= nxt_pwm;
            act_res_ff <= take_settings ? mode_ff.res : act_res_ff;
            act_rate_ff <= take_settings ? mode_ff.rate : act_rate_ff;
            act_src_ff <= take_settings ? mode_ff.src_hosc : act_src_ff;
        end
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    pct_prescaler u_prescaler (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_run(run),
        .i_src_hosc(act_src_ff),
        .i_rate(act_rate_ff),
        .i_cpu_tick(i_cpu_tick),
        .i_hosc_tick(i_hosc_tick),
        .o_tick(pre_tick)
    );

    pct_pin_mux u_pin_mux (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_pin_en(mode_ff.pin_en),
        .i_run(run),
        .i_wave(pwm_ff),
        .i_gpio_out(i_gpio_out),
        .i_gpio_oe(i_gpio_oe),
        .o_pin_out(o_pin_out),
        .o_pin_oe(o_pin_oe)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_awready = awready_ff;
    assign o_wready = wready_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    sequence s_overflow;
        ovf && !sw_count_wr;
    endsequence

    sequence s_plain_step;
        step && !ovf && !sw_count_wr;
    endsequence

    AST_RESET_ZERO: assert property (@(posedge i_clock) disable iff (1'b0)
        i_srst |=> (mode_ff == pct_mode_s'(`PCT_RST_BYTE)) && (count_ff == `PCT_RST_BYTE) && (reload_ff == `PCT_RST_BYTE))
        else $error("registers not cleared by reset");

    AST_RELOAD_ON_OVF: assert property (s_overflow |=> count_ff == $past(reload_ff))
        else $error("count not reloaded at overflow");

    AST_STEP_ONE: assert property (s_plain_step |=> count_ff == 8'($past(count_ff) + 8'h01))
        else $error("count did not advance by one");

    AST_HOLD_STOPPED: assert property (!run && !sw_count_wr |=> $stable(count_ff))
        else $error("stopped counter changed");

    AST_HIGH_AFTER_OVF: assert property (s_overflow |=> pwm_ff ##1 (pwm_ff || $past(duty_hit)))
        else $error("waveform not high at period start");

    AST_LOW_AT_DUTY: assert property (duty_hit |=> !pwm_ff)
        else $error("waveform did not fall at duty match");

    AST_RES_HELD: assert property (run && !ovf |=> $stable(act_res_ff) && $stable(act_rate_ff))
        else $error("period setting changed mid period");

    AST_PIN_PORT: assert property (!mode_ff.pin_en |=> (o_pin_out == $past(i_gpio_out)) && (o_pin_oe == $past(i_gpio_oe)))
        else $error("pin not returned to port control");

    AST_PIN_WAVE: assert property (mode_ff.pin_en && run |=> o_pin_oe && (o_pin_out == $past(pwm_ff)))
        else $error("waveform not on owned pin");

    AST_WR_ANSWER: assert property (do_write |=> o_bvalid && (wr_state_ff == PCT_BUS_RESP))
        else $error("write not answered one cycle after commit");

    AST_OVF_AT_TOP: assert property (step |-> ovf == (
        (act_res_ff == `PCT_RES_256) ? (count_ff == `PCT_TOP_256) :
        (act_res_ff == `PCT_RES_64) ? ((count_ff & `PCT_TOP_64) == `PCT_TOP_64) :
        (act_res_ff == `PCT_RES_32) ? ((count_ff & `PCT_TOP_32) == `PCT_TOP_32) :
        ((count_ff & `PCT_TOP_16) == `PCT_TOP_16)))
        else $error("overflow away from range top");
endmodule
`default_nettype wire

// *** pct_load_model.sv ***
// Load on the shared pin: resolves the pin level seen by the outside world
`default_nettype none
module pct_load_model (
    // Clock
    input wire logic i_clock,
    // Pin drive from the channel
    input wire logic i_pin_out,
    input wire logic i_pin_oe,
    // Resolved level and rise count
    output logic o_level,
    output int o_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_ff;
    // A weak pull-down holds the pin low whenever nobody drives it
    assign o_level = i_pin_oe ? i_pin_out : 1'b0;
    initial o_rises = 0;
    initial last_ff = 1'b0;
    always @(posedge i_clock) begin
        if (o_level && !last_ff) begin
            o_rises <= o_rises + 1;
        end
        last_ff <= o_level;
    end
endmodule
`default_nettype wire

// *** pwm_channel_timer_tb.sv ***
// Self-checking testbench of the pwm channel counter
`default_nettype none
`include "pct_regs.svh"
module pwm_channel_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pct_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clock = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic cpu_tick = 0, hosc_tick = 0, gpio_out = 0, gpio_oe = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, level;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    int err_total = 0, comparisons = 0, rises;

    pct_top dut_u (.i_clock(clock), .i_srst(srst), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
        .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .i_cpu_tick(cpu_tick), .i_hosc_tick(hosc_tick),
        .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe));
    pct_load_model load_u (.i_clock(clock), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_level(level),
        .o_rises(rises));

    initial begin
        forever #5 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic axi_write(input logic [11:0] a, input logic [7:0] v, output logic [1:0] resp);
        int n;
        logic done;
        done = 0;
        resp = 2'h3;
        @(posedge clock);
        awaddr <= a; wdata <= {24'h000000, v}; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp; bready <= 1'b0; done = 1;
            end
        end
        if (!done) begin
            check({31'h0, done}, 32'h00000001);
            stop_test();
        end
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        logic done;
        done = 0;
        resp = 2'h3;
        v = 32'hFFFFFFFF;
        @(posedge clock);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata; resp = rresp; rready <= 1'b0; done = 1;
            end
        end
        if (!done) begin
            check({31'h0, done}, 32'h00000001);
            stop_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        axi_write(a, v, r);
        check({30'h0, r}, {30'h0, `PCT_RESP_OKAY});
    endtask

    task automatic rd_check(input logic [11:0] a, input logic [7:0] exp);
        axi_read(a, d, r);
        check(d, {24'h000000, exp});
        check({30'h0, r}, {30'h0, `PCT_RESP_OKAY});
    endtask

    // Single-cycle source pulses two cycles apart, then time for the pin to follow
    task automatic ticks(input logic hosc, input int n);
        repeat (n) begin
            @(posedge clock);
            if (hosc) hosc_tick <= 1'b1;
            else cpu_tick <= 1'b1;
            @(posedge clock);
            hosc_tick <= 1'b0; cpu_tick <= 1'b0;
        end
        repeat (4) @(posedge clock);
    endtask

    function automatic logic [7:0] md(logic run, logic [2:0] rate, logic src, logic [1:0] res, logic pin);
        return {run, rate, src, res, pin};
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd_check(`PCT_ADDR_MODE, 8'h00);
        rd_check(`PCT_ADDR_COUNT, 8'h00);
        wr(`PCT_ADDR_RELOAD, 8'h5A);
        rd_check(`PCT_ADDR_RELOAD, 8'h00);
        wr(`PCT_ADDR_COUNT, 8'h3C);
        rd_check(`PCT_ADDR_COUNT, 8'h3C);
        wr(`PCT_ADDR_MODE, 8'h7E);
        rd_check(`PCT_ADDR_MODE, 8'h7E);
        axi_write(12'h000, 8'h11, r);
        check({30'h0, r}, {30'h0, `PCT_RESP_SLVERR});
        axi_read(12'h000, d, r);
        check({30'h0, r}, {30'h0, `PCT_RESP_SLVERR});
        check(d, `PCT_RDATA_ZERO);
        wr(`PCT_ADDR_MODE, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_pin;
        @(posedge clock);
        gpio_oe <= 1'b1; gpio_out <= 1'b1;
        repeat (3) @(posedge clock);
        check({pin_oe, pin_out}, 2'b11);
        wr(`PCT_ADDR_MODE, md(0, 3'h0, 0, 2'h0, 1));
        repeat (3) @(posedge clock);
        check({pin_oe, pin_out}, 2'b10);
        wr(`PCT_ADDR_MODE, 8'h00);
        repeat (3) @(posedge clock);
        check({pin_oe, pin_out}, 2'b11);
        $display("test pin done");
    endtask

    // Each rate and source: two times the divisor of source pulses must give two counts
    task automatic t_rates;
        int div;
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 8; k++) begin
                div = (s == 1) ? (1 << (7 - k)) : (1 << (8 - k));
                wr(`PCT_ADDR_COUNT, 8'h00);
                wr(`PCT_ADDR_MODE, md(0, k[2:0], s[0], 2'h0, 0));
                wr(`PCT_ADDR_MODE, md(1, k[2:0], s[0], 2'h0, 0));
                ticks(s[0], 2 * div);
                wr(`PCT_ADDR_MODE, md(0, k[2:0], s[0], 2'h0, 0));
                rd_check(`PCT_ADDR_COUNT, 8'h02);
            end
        end
        $display("test rates done");
    endtask

    // Two steps from one below the top must wrap through the reload value
    task automatic t_overflow;
        logic [7:0] top;
        for (int res = 0; res < 4; res++) begin
            top = (res == 0) ? 8'hFF : (8'hFF >> (res + 1));
            wr(`PCT_ADDR_RELOAD, 8'h05);
            wr(`PCT_ADDR_COUNT, top - 8'h01);
            wr(`PCT_ADDR_MODE, md(0, 3'h7, 1, res[1:0], 0));
            wr(`PCT_ADDR_MODE, md(1, 3'h7, 1, res[1:0], 0));
            ticks(1, 2);
            wr(`PCT_ADDR_MODE, md(0, 3'h7, 1, res[1:0], 0));
            rd_check(`PCT_ADDR_COUNT, 8'h05);
        end
        $display("test overflow done");
    endtask

    task automatic t_wave;
        int r0;
        @(posedge clock);
        gpio_oe <= 1'b0;
        wr(`PCT_ADDR_MODE, 8'h00);
        wr(`PCT_ADDR_RELOAD, 8'h03);
        wr(`PCT_ADDR_COUNT, 8'h00);
        wr(`PCT_ADDR_MODE, md(0, 3'h7, 1, 2'h3, 1));
        wr(`PCT_ADDR_MODE, md(1, 3'h7, 1, 2'h3, 1));
        repeat (3) @(posedge clock);
        check({31'h0, level}, 32'h1);
        r0 = rises;
        for (int k = 1; k <= 16; k++) begin
            ticks(1, 1);
            check({31'h0, level}, {31'h0, (k < 3 || k == 16)});
            // Period widened mid-run; the running period must still end at 16
            if (k == 8) wr(`PCT_ADDR_MODE, md(1, 3'h7, 1, 2'h2, 1));
        end
        check(rises - r0, 1);
        wr(`PCT_ADDR_MODE, md(1, 3'h7, 1, 2'h2, 0));
        repeat (3) @(posedge clock);
        check({pin_oe, pin_out}, 2'b01);
        wr(`PCT_ADDR_MODE, 8'h00);
        axi_read(`PCT_ADDR_COUNT, d, r);
        check(d, 32'h00000003);
        ticks(1, 3);
        rd_check(`PCT_ADDR_COUNT, 8'h03);
        $display("test wave done");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        t_regs();
        t_pin();
        t_rates();
        t_overflow();
        t_wave();
        stop_test();
    end
endmodule
`default_nettype wire
